// [hw/pmic_seq_pkg.sv]
package pmic_seq_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1_000_000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam int NCH           = 6;
  localparam int NREG          = 4;
  localparam int NFLAG         = 12;
  // Flag bit positions
  localparam int F_LIM   = 0;
  localparam int F_SHORT = 4;
  localparam int F_WARN  = 8;
  localparam int F_HOT   = 9;
  localparam int F_OVP   = 10;
  localparam int F_RST   = 11;
  localparam logic [NFLAG-1:0] IRQ_MASKABLE = 12'h10f;
  // Milliseconds per wait code
  localparam logic [5:0] DELAY_MS [16] = '{
    6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07,
    6'h08, 6'h0a, 6'h0c, 6'h0e, 6'h10, 6'h14, 6'h18, 6'h20};

  typedef enum {ST_OFF, ST_LOAD, ST_RUN} phase_t;

  // Channels 0..1 step-down, 2..3 linear, 4..5 general outputs
  typedef struct packed {
    logic [NCH-1:0]       on_bit;
    logic [NCH-1:0]       pin_select;
    logic [NCH-1:0][3:0]  rise_wait;
    logic [NCH-1:0][3:0]  fall_wait;
    logic [1:0][7:0]      step_down_voltage_code;
    logic [1:0][4:0]      linear_voltage_code;
    logic [NFLAG-1:0]     irq_mask;
  } cfg_t;

  typedef struct packed {
    logic [NREG-1:0] rail_low;
    logic [NREG-1:0] rail_limit;
    logic            hot_warn;
    logic            hot_sd;
    logic            overvolt;
  } mon_t;

  localparam cfg_t CFG_DEFAULT = '0;

  function automatic logic [5:0] delay_ms(input logic [3:0] code);
    return DELAY_MS[code];
  endfunction
endpackage

// [hw/pmic_sequence_reset_fault.sv]
module pmic_sequence_reset_fault import pmic_seq_pkg::*; #(
  parameter int   MS_COUNT            = MS_CYCLES,
  parameter cfg_t FACTORY_CFG         = CFG_DEFAULT,
  parameter logic FACTORY_RESET_MASK  = 1'b0
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // Pins and analog monitors
  input  wire logic               en_pin,
  input  wire logic               analog_supply_low,
  input  wire mon_t               mon_in,
  // Configuration writes
  input  wire logic               cfg_wr,
  input  wire cfg_t               cfg_wdata,
  input  wire logic               soft_reset_wr,
  input  wire logic [NFLAG-1:0]   flag_clear,
  // Outputs
  output logic [NCH-1:0]          rail_on,
  output logic [1:0][7:0]         step_down_vout,
  output logic [1:0][4:0]         linear_vout,
  output logic [NFLAG-1:0]        flags,
  output logic [6:0]              status,
  output logic                    irq_n_pin,
  output logic                    soft_reset_bit,
  output logic                    ready,
  output cfg_t                    cfg_out
);
  localparam int CW = $clog2(MS_COUNT + 1);

  //////////////////////////////////////////////////////////////////////////
  // Synchronisers
  mon_t mon_s1_reg, mon_s2_reg;
  logic en_s1_reg, en_s2_reg, en_prev_reg, uv_s1_reg, uv_s2_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      mon_s1_reg  <= '0;
      mon_s2_reg  <= '0;
      en_s1_reg   <= 1'b0;
      en_s2_reg   <= 1'b0;
      en_prev_reg <= 1'b0;
      uv_s1_reg   <= 1'b0;
      uv_s2_reg   <= 1'b0;
    end else begin
      mon_s1_reg  <= mon_in;
      mon_s2_reg  <= mon_s1_reg;
      en_s1_reg   <= en_pin;
      en_s2_reg   <= en_s1_reg;
      en_prev_reg <= en_s2_reg;
      uv_s1_reg   <= analog_supply_low;
      uv_s2_reg   <= uv_s1_reg;
    end
  end

  logic en_rise, en_fall;
  assign en_rise = en_s2_reg & ~en_prev_reg;
  assign en_fall = ~en_s2_reg & en_prev_reg;

  //////////////////////////////////////////////////////////////////////////
  // Reset phases and configuration
  phase_t phase_reg, phase_next;
  cfg_t   cfg_reg, cfg_next;
  logic   srst_reg, srst_next, rmask_reg, rmask_next, ready_reg, ready_next;
  logic   kill;

  always_comb begin
    phase_next = phase_reg;
    srst_next  = 1'b0;
    cfg_next   = cfg_reg;
    rmask_next = rmask_reg;
    if (uv_s2_reg) begin
      phase_next = ST_OFF;
    end else begin
      unique case (phase_reg)
        ST_OFF:  phase_next = ST_LOAD;
        ST_LOAD: phase_next = ST_RUN;
        ST_RUN:  if (srst_reg) phase_next = ST_LOAD;
      endcase
    end
    ready_next = (phase_next == ST_RUN);
    if (phase_reg == ST_RUN && !srst_reg) srst_next = soft_reset_wr;
    if (phase_reg == ST_OFF) begin
      cfg_next = CFG_DEFAULT;
    end else if (phase_reg == ST_LOAD) begin
      cfg_next = FACTORY_CFG;
      rmask_next = FACTORY_RESET_MASK;
    end else if (cfg_wr && !srst_reg) begin
      cfg_next = cfg_wdata;
    end
  end

  // No serial state here; the host link lives outside this reset
  always_ff @(posedge clk) begin
    if (reset) begin
      phase_reg <= ST_OFF;
      cfg_reg   <= CFG_DEFAULT;
      srst_reg  <= 1'b0;
      rmask_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      cfg_reg   <= cfg_next;
      srst_reg  <= srst_next;
      rmask_reg <= rmask_next;
      ready_reg <= ready_next;
    end
  end

  assign kill = (phase_reg != ST_RUN) | srst_reg | mon_s2_reg.hot_sd | mon_s2_reg.overvolt;

  //////////////////////////////////////////////////////////////////////////
  // Millisecond tick; sequence waits may run up to one tick short
  logic [CW-1:0] tick_cnt_reg, tick_cnt_next;
  logic          tick;
  assign tick = (tick_cnt_reg == CW'(MS_COUNT - 1));
  always_comb tick_cnt_next = tick ? '0 : tick_cnt_reg + 1'b1;
  always_ff @(posedge clk) begin
    if (reset) tick_cnt_reg <= '0;
    else       tick_cnt_reg <= tick_cnt_next;
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin sequencing per channel
  logic [NCH-1:0]      seq_reg, seq_next, pend_reg, pend_next, sel, req;
  logic [NCH-1:0][5:0] wait_reg, wait_next;

  always_comb begin
    seq_next  = seq_reg;
    pend_next = pend_reg;
    wait_next = wait_reg;
    for (int i = 0; i < NCH; i++) begin
      sel[i] = cfg_reg.on_bit[i] & cfg_reg.pin_select[i];
      if (!sel[i]) begin
        pend_next[i] = 1'b0;
        seq_next[i]  = en_s2_reg;
      end else if (en_rise || en_fall) begin
        pend_next[i] = 1'b1;
        wait_next[i] = delay_ms(en_rise ? cfg_reg.rise_wait[i] : cfg_reg.fall_wait[i]);
      end else if (pend_reg[i]) begin
        if (wait_reg[i] == 6'h00) begin
          seq_next[i]  = en_s2_reg;
          pend_next[i] = 1'b0;
        end else if (tick) begin
          wait_next[i] = wait_reg[i] - 6'h01;
        end
      end
      req[i] = cfg_reg.on_bit[i] & (cfg_reg.pin_select[i] ? seq_reg[i] : 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      seq_reg  <= '0;
      pend_reg <= '0;
      wait_reg <= '0;
    end else begin
      seq_reg  <= seq_next;
      pend_reg <= pend_next;
      wait_reg <= wait_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Short detection and rail outputs
  logic [NREG-1:0][CW-1:0] sc_cnt_reg, sc_cnt_next;
  logic [NREG-1:0]         sc_off_reg, sc_off_next, sc_hit;
  logic [NCH-1:0]          rail_reg, rail_next;
  logic [1:0][7:0]         bv_reg, bv_next;
  logic [1:0][4:0]         lv_reg, lv_next;

  always_comb begin
    for (int r = 0; r < NREG; r++) begin
      sc_hit[r]      = rail_reg[r] & mon_s2_reg.rail_low[r] &
                       (sc_cnt_reg[r] == CW'(MS_COUNT - 1));
      sc_cnt_next[r] = (rail_reg[r] && mon_s2_reg.rail_low[r] && !sc_hit[r]) ?
                       sc_cnt_reg[r] + 1'b1 : '0;
      sc_off_next[r] = req[r] & (sc_off_reg[r] | sc_hit[r]);
    end
    rail_next = req & {NCH{~kill}} & {2'b11, ~(sc_off_reg | sc_hit)};
    for (int b = 0; b < 2; b++) begin
      bv_next[b] = rail_next[b] ? cfg_reg.step_down_voltage_code[b] : 8'h00;
      lv_next[b] = rail_next[b+2] ? cfg_reg.linear_voltage_code[b] : 5'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sc_cnt_reg <= '0;
      sc_off_reg <= '0;
      rail_reg   <= '0;
      bv_reg     <= '0;
      lv_reg     <= '0;
    end else begin
      sc_cnt_reg <= sc_cnt_next;
      sc_off_reg <= sc_off_next;
      rail_reg   <= rail_next;
      bv_reg     <= bv_next;
      lv_reg     <= lv_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Flags and interrupt; a set always wins over a clear
  logic [NFLAG-1:0] flags_reg, flags_next, set_v, hold_v;
  logic             rpend_reg, rpend_next, irq_n_reg, irq_n_next;
  logic [6:0]       stat_reg, stat_next;

  always_comb begin
    // Remember fault or reset until next start-up
    rpend_next = rpend_reg | kill;
    set_v      = '0;
    if (!kill && rpend_reg) begin
      rpend_next   = 1'b0;
      set_v[F_RST] = ~rmask_reg;
    end
    set_v[F_LIM+:4]         = mon_s2_reg.rail_limit;
    set_v[F_WARN]           = mon_s2_reg.hot_warn;
    set_v[F_SHORT+:4]       = sc_hit;
    set_v[F_HOT]            = mon_s2_reg.hot_sd;
    set_v[F_OVP]            = mon_s2_reg.overvolt;
    hold_v                  = set_v;
    hold_v[F_SHORT+:4]      = 4'h0;
    hold_v[F_RST]           = 1'b0;
    if (phase_reg != ST_RUN || srst_reg) begin
      flags_next = '0;
    end else begin
      flags_next = set_v | (flags_reg & ~(flag_clear & ~hold_v));
    end
    irq_n_next = ~|(flags_reg & ~(cfg_reg.irq_mask & IRQ_MASKABLE));
    stat_next  = {mon_s2_reg.overvolt, mon_s2_reg.hot_sd, mon_s2_reg.hot_warn,
                  mon_s2_reg.rail_limit};
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      flags_reg <= '0;
      rpend_reg <= 1'b1;
      irq_n_reg <= 1'b1;
      stat_reg  <= '0;
    end else begin
      flags_reg <= flags_next;
      rpend_reg <= rpend_next;
      irq_n_reg <= irq_n_next;
      stat_reg  <= stat_next;
    end
  end

  assign rail_on        = rail_reg;
  assign step_down_vout = bv_reg;
  assign linear_vout    = lv_reg;
  assign flags          = flags_reg;
  assign status         = stat_reg;
  assign irq_n_pin      = irq_n_reg;
  assign soft_reset_bit = srst_reg;
  assign ready          = ready_reg;
  assign cfg_out        = cfg_reg;

  //////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_off_bit;
    1'b1 |=> ((rail_reg & ~$past(cfg_reg.on_bit)) == '0);
  endproperty
  a_off_bit: assert property (p_off_bit) else $error("rail on with on bit low");

  property p_reg_ctrl;
    cfg_reg.on_bit[4] && !cfg_reg.pin_select[4] && !kill |=> rail_reg[4];
  endproperty
  a_reg_ctrl: assert property (p_reg_ctrl) else $error("register control not immediate");

  property p_rise0;
    en_rise && sel[4] && cfg_reg.rise_wait[4] == 4'h0 ##1 en_s2_reg && sel[4]
      |=> seq_reg[4];
  endproperty
  a_rise0: assert property (p_rise0) else $error("zero rise wait not honoured");

  property p_fall0;
    en_fall && sel[4] && cfg_reg.fall_wait[4] == 4'h0 ##1 !en_s2_reg && sel[4]
      |=> !seq_reg[4];
  endproperty
  a_fall0: assert property (p_fall0) else $error("zero fall wait not honoured");

  property p_kill;
    kill |=> rail_reg == '0;
  endproperty
  a_kill: assert property (p_kill) else $error("output alive during kill");

  property p_srst;
    srst_reg |=> !srst_reg ##1 phase_reg == ST_RUN || uv_s2_reg;
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset bit stuck");

  property p_irq_hot;
    flags_reg[F_HOT] |=> !irq_n_reg;
  endproperty
  a_irq_hot: assert property (p_irq_hot) else $error("irq pin not low");

  property p_ovp_hold;
    flags_reg[F_OVP] && mon_s2_reg.overvolt && phase_reg == ST_RUN && !srst_reg
      |=> flags_reg[F_OVP];
  endproperty
  a_ovp_hold: assert property (p_ovp_hold) else $error("ovp flag cleared early");

  property p_short;
    sc_hit[0] && phase_reg == ST_RUN && !srst_reg |=> !rail_reg[0] && flags_reg[F_SHORT];
  endproperty
  a_short: assert property (p_short) else $error("short not handled");

  property p_uvlo_rel;
    phase_reg == ST_OFF && !uv_s2_reg ##1 !uv_s2_reg |-> phase_reg == ST_LOAD ##1
      (phase_reg == ST_RUN || uv_s2_reg);
  endproperty
  a_uvlo_rel: assert property (p_uvlo_rel) else $error("lockout release sequence");

  c_srst:  cover property (srst_reg ##2 phase_reg == ST_RUN);
  c_seq:   cover property (en_rise && sel[0] ##[1:50] rail_reg[0]);
  c_short: cover property (sc_hit[2]);
endmodule // pmic_sequence_reset_fault

// [tb/host_model.sv]
module host_model import pmic_seq_pkg::*; #(
  parameter int POR_WAIT = 24
) (
  // Clock and device state
  input  wire logic             clk,
  input  wire logic             ready,
  // Host requests
  output logic                  en_pin,
  output logic                  cfg_wr,
  output cfg_t                  cfg_wdata,
  output logic                  soft_reset_wr,
  output logic [NFLAG-1:0]      flag_clear
);
  timeunit 1ns;
  timeprecision 1ps;

  int since_ready = 0;

  always @(posedge clk) since_ready <= (ready === 1'b1) ? since_ready + 1 : 0;

  initial begin
    en_pin        = 1'b0;
    cfg_wr        = 1'b0;
    cfg_wdata     = '0;
    soft_reset_wr = 1'b0;
    flag_clear    = '0;
  end

  //////////////////////////////////////////////////////////////////////////
  // Config and soft-reset writes only after the power-on wait; clear() does not wait
  task automatic wait_ready();
    int n;
    n = 0;
    while ((ready !== 1'b1 || since_ready < POR_WAIT) && n < 500) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic set_en(input logic v);
    @(posedge clk);
    #1;
    en_pin = v;
  endtask

  // Whole struct in one pulse
  task automatic write_cfg(input cfg_t c);
    wait_ready();
    @(posedge clk);
    #1;
    cfg_wdata = c;
    cfg_wr    = 1'b1;
    @(posedge clk);
    #1;
    cfg_wr = 1'b0;
  endtask

  task automatic soft_reset();
    wait_ready();
    @(posedge clk);
    #1;
    soft_reset_wr = 1'b1;
    @(posedge clk);
    #1;
    soft_reset_wr = 1'b0;
  endtask

  task automatic clear(input logic [NFLAG-1:0] v);
    @(posedge clk);
    #1;
    flag_clear = v;
    @(posedge clk);
    #1;
    flag_clear = '0;
  endtask
endmodule // host_model

// [tb/pmic_sequence_reset_fault_bench.sv]
module pmic_sequence_reset_fault_bench import pmic_seq_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int   MSC  = 20;
  localparam cfg_t FCFG = '{on_bit: 6'h01, pin_select: 6'h00, rise_wait: '0, fall_wait: '0,
    step_down_voltage_code: 16'h005a, linear_voltage_code: 10'h000, irq_mask: 12'h000};

  logic                  clk = 1'b0;
  logic                  reset;
  logic                  en_pin;
  logic                  analog_supply_low;
  mon_t                  mon_in;
  logic                  cfg_wr;
  cfg_t                  cfg_wdata;
  logic                  soft_reset_wr;
  logic [NFLAG-1:0]      flag_clear;
  logic [NCH-1:0]        rail_on;
  logic [1:0][7:0]       step_down_vout;
  logic [1:0][4:0]       linear_vout;
  logic [NFLAG-1:0]      flags;
  logic [6:0]            status;
  logic                  irq_n_pin;
  logic                  soft_reset_bit;
  logic                  ready;
  cfg_t                  cfg_out;
  int                    bad_count = 0;
  int                    comparisons = 0;
  int                    cyc = 0;
  int                    t0 = 0;
  int                    sr_seen = 0;

  always #5 clk = ~clk;

  pmic_sequence_reset_fault #(.MS_COUNT(MSC), .FACTORY_CFG(FCFG)) u_pmic_sequence_reset_fault (
    .clk(clk), .reset(reset), .en_pin(en_pin), .analog_supply_low(analog_supply_low),
    .mon_in(mon_in), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .soft_reset_wr(soft_reset_wr),
    .flag_clear(flag_clear), .rail_on(rail_on), .step_down_vout(step_down_vout),
    .linear_vout(linear_vout), .flags(flags), .status(status), .irq_n_pin(irq_n_pin),
    .soft_reset_bit(soft_reset_bit), .ready(ready), .cfg_out(cfg_out));

  host_model #(.POR_WAIT(MSC * 12 / 10)) u_host_model (
    .clk(clk), .ready(ready), .en_pin(en_pin), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
    .soft_reset_wr(soft_reset_wr), .flag_clear(flag_clear));

  //////////////////////////////////////////////////////////////////////////
  // Hang guard, well above the expected run
  always @(posedge clk) begin
    cyc++;
    if (soft_reset_bit === 1'b1) sr_seen++;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Elapsed edges since t0 until the rail reaches v
  task automatic timed(input int ch, input logic v, input int lo, input int hi);
    while (rail_on[ch] !== v && cyc - t0 < 200) step(1);
    check("rail timing", (cyc - t0 >= lo) && (cyc - t0 <= hi), 1'b1);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic test_power_up();
    u_host_model.wait_ready();
    step(4);
    check("rail_on", rail_on, 6'h01);
    check("vout0", step_down_vout[0], 8'h5a);
    check("ready", ready, 1'b1);
    check("flags", flags, 12'h800);
    check("irq_n", irq_n_pin, 1'b0);
    u_host_model.clear(12'h800);
    step(3);
    check("irq_n", irq_n_pin, 1'b1);
    $display("test power_up done");
  endtask

  task automatic test_register();
    cfg_t c;
    c = '0;
    c.on_bit = 6'h09;
    c.pin_select = 6'h02;
    c.rise_wait[3] = 4'hf;
    c.linear_voltage_code[1] = 5'h13;
    u_host_model.set_en(1'b1);
    u_host_model.write_cfg(c);
    step(3);
    check("cfg_out", cfg_out, c);
    check("rail_on", rail_on, 6'h09);
    check("lin vout1", linear_vout[1], 5'h13);
    check("bv vout1", step_down_vout[1], 8'h00);
    u_host_model.set_en(1'b0);
    // Pin must settle before rails become pin selected
    step(4);
    $display("test register done");
  endtask

  task automatic test_sequence();
    cfg_t c;
    c = '0;
    c.on_bit = 6'h15;
    c.pin_select = 6'h15;
    c.rise_wait[0] = 4'h2;
    c.rise_wait[2] = 4'h1;
    c.fall_wait[2] = 4'h3;
    c.fall_wait[0] = 4'h1;
    u_host_model.write_cfg(c);
    step(3);
    check("idle rails", rail_on, 6'h00);
    u_host_model.set_en(1'b1);
    t0 = cyc;
    timed(4, 1'b1, 0, 6);
    timed(2, 1'b1, 0, 26);
    timed(0, 1'b1, MSC, 2 * MSC + 6);
    u_host_model.set_en(1'b0);
    t0 = cyc;
    timed(4, 1'b0, 0, 6);
    timed(0, 1'b0, 0, MSC + 6);
    timed(2, 1'b0, 2 * MSC, 3 * MSC + 6);
    $display("test sequence done");
  endtask

  task automatic test_soft_reset();
    cfg_t c;
    int   n0;
    c = '0;
    c.on_bit = 6'h3f;
    c.irq_mask = 12'hfff;
    c.step_down_voltage_code[1] = 8'hc3;
    c.linear_voltage_code[0] = 5'h0e;
    u_host_model.write_cfg(c);
    step(3);
    check("bv vout1", step_down_vout[1], 8'hc3);
    check("lin vout0", linear_vout[0], 5'h0e);
    n0 = sr_seen;
    u_host_model.soft_reset();
    step(1);
    check("ready", ready, 1'b0);
    check("rail_on", rail_on, 6'h00);
    step(6);
    check("pulses", sr_seen - n0, 1);
    check("ready", ready, 1'b1);
    check("cfg_out", cfg_out, FCFG);
    check("bv vout1", step_down_vout[1], 8'h00);
    check("flags", flags, 12'h800);
    check("irq_n", irq_n_pin, 1'b0);
    u_host_model.clear(12'h800);
    $display("test soft_reset done");
  endtask

  task automatic test_faults();
    cfg_t c;
    int   mb[5] = '{3, 2, 1, 0, 6};
    int   fb[5] = '{0, 8, 9, 10, 3};
    int   sb[5] = '{0, 4, 5, 6, 3};
    logic kill;
    c = '0;
    c.on_bit = 6'h3f;
    c.irq_mask = 12'h001;
    u_host_model.write_cfg(c);
    for (int i = 0; i < 5; i++) begin
      kill = (i == 2 || i == 3);
      step(3);
      mon_in[mb[i]] = 1'b1;
      step(5);
      check("flag", flags[fb[i]], 1'b1);
      check("status", status, 7'h01 << sb[i]);
      check("rails", rail_on, kill ? 6'h00 : 6'h3f);
      check("irq_n", irq_n_pin, i == 0);
      u_host_model.clear(12'h001 << fb[i]);
      step(3);
      check("held", flags[fb[i]], 1'b1);
      mon_in[mb[i]] = 1'b0;
      step(6);
      u_host_model.clear(12'h001 << fb[i]);
      step(4);
      check("flags", flags, {kill, 11'h000});
      u_host_model.clear(12'hfff);
    end
    $display("test faults done");
  endtask

  task automatic test_short();
    for (int ch = 0; ch < 4; ch++) begin
      step(3);
      mon_in.rail_low[ch] = 1'b1;
      step(MSC - 6);
      check("early", rail_on[ch], 1'b1);
      step(14);
      check("off", rail_on[ch], 1'b0);
      check("flag", flags[F_SHORT + ch], 1'b1);
      check("irq_n", irq_n_pin, 1'b0);
      mon_in.rail_low[ch] = 1'b0;
      u_host_model.clear(12'h010 << ch);
      step(3);
      check("cleared", flags, 12'h000);
    end
    $display("test short done");
  endtask

  task automatic test_lockout();
    analog_supply_low = 1'b1;
    step(4);
    check("rails", rail_on, 6'h00);
    check("cfg", cfg_out, CFG_DEFAULT);
    check("ready", ready, 1'b0);
    analog_supply_low = 1'b0;
    u_host_model.wait_ready();
    step(4);
    check("cfg", cfg_out, FCFG);
    check("rails", rail_on, 6'h01);
    check("flags", flags, 12'h800);
    $display("test lockout done");
  endtask

  initial begin
    reset = 1'b1;
    analog_supply_low = 1'b0;
    mon_in = '0;
    repeat (8) @(posedge clk);
    #1;
    reset = 1'b0;
    test_power_up();
    test_register();
    test_sequence();
    test_soft_reset();
    test_faults();
    test_short();
    test_lockout();
    summarize();
  end
endmodule // pmic_sequence_reset_fault_bench
